// ===== hdl/opd_pkg.sv
// Shared constants and carrier types for the output dependency block
package opd_pkg;

    localparam int ADDR_W = 12;
    localparam int IDX_W  = 10;
    localparam int SYNC_W = 2;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_P1_PRIMARY   = 10'h016;
    localparam logic [IDX_W-1:0] IDX_P1_SECONDARY = 10'h017;
    localparam logic [IDX_W-1:0] IDX_P1_PEERS     = 10'h018;
    localparam logic [IDX_W-1:0] IDX_P2_PRIMARY   = 10'h019;
    localparam logic [IDX_W-1:0] IDX_P2_SECONDARY = 10'h01a;
    localparam logic [IDX_W-1:0] IDX_P2_PEERS     = 10'h01b;
    localparam logic [IDX_W-1:0] IDX_EIGHTH       = 10'h01c;
    localparam logic [IDX_W-1:0] IDX_MANUAL       = 10'h040;
    localparam logic [IDX_W-1:0] IDX_STATUS       = 10'h050;

    localparam int CFG_SLOTS = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Field positions
    localparam int EIGHTH_P1_BIT  = 0;
    localparam int EIGHTH_P2_BIT  = 1;
    localparam int MANUAL_SEL_BIT = 2;

    // Condition source vector layout
    localparam int SRC_W      = 26;
    localparam int SRC_PRIM   = 0;
    localparam int SRC_WDOG   = 6;
    localparam int SRC_SEC    = 8;
    localparam int SRC_GPI_LO = 14;
    localparam int SRC_GPI_HI = 16;
    localparam int SRC_PEER12 = 18;
    localparam int SRC_PEERHI = 20;
    localparam int SRC_EIGHTH = 24;
    localparam int SRC_MANUAL = 25;

    // Sources that exist only on the wide variants
    localparam logic [SRC_W-1:0] DET56_BITS    = 26'h0003030;
    localparam logic [SRC_W-1:0] OUT_WIDE_BITS = 26'h10c0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } opd_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } opd_axil_rsp_t;

endpackage

// ===== hdl/opd_axil_slave.sv
// AXI4-Lite slave front end with byte-wide register access
`timescale 1ns/1ns
module opd_axil_slave (
    input  wire logic                   clk_in,
    input  wire logic                   arst_n_in,
    input  wire opd_pkg::opd_axil_req_t axil_req_in,
    output opd_pkg::opd_axil_rsp_t      axil_rsp_out,
    output logic                        wr_en_out,
    output logic [opd_pkg::IDX_W-1:0]   wr_idx_out,
    output logic [7:0]                  wr_data_out,
    input  wire logic                   wr_hit_in,
    output logic [opd_pkg::IDX_W-1:0]   rd_idx_out,
    input  wire logic                   rd_hit_in,
    input  wire logic [7:0]             rd_data_in
);
    import opd_pkg::*;

    logic              aw_held_q;
    logic              w_held_q;
    logic [IDX_W-1:0]  awidx_q;
    logic [7:0]        wdata_q;
    logic              wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic              do_wr;

    assign aw_take = axil_req_in.awvalid && !aw_held_q && !bvalid_q;
    assign w_take  = axil_req_in.wvalid && !w_held_q && !bvalid_q;
    assign ar_take = axil_req_in.arvalid && !rvalid_q;
    assign do_wr   = aw_held_q && w_held_q && !bvalid_q;

    assign wr_en_out   = do_wr && wr_hit_in && wstrb_q;
    assign wr_idx_out  = awidx_q;
    assign wr_data_out = wdata_q;
    assign rd_idx_out  = axil_req_in.araddr[ADDR_W-1:2];

    assign axil_rsp_out.awready = !aw_held_q && !bvalid_q;
    assign axil_rsp_out.wready  = !w_held_q && !bvalid_q;
    assign axil_rsp_out.bvalid  = bvalid_q;
    assign axil_rsp_out.bresp   = bresp_q;
    assign axil_rsp_out.arready = !rvalid_q;
    assign axil_rsp_out.rvalid  = rvalid_q;
    assign axil_rsp_out.rdata   = rdata_q;
    assign axil_rsp_out.rresp   = rresp_q;

    // Address and data may arrive in either order
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awidx_q   <= '0;
            wdata_q   <= 8'h00;
            wstrb_q   <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awidx_q   <= axil_req_in.awaddr[ADDR_W-1:2];
            end else if (do_wr) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q  <= axil_req_in.wdata[7:0];
                wstrb_q  <= axil_req_in.wstrb[0];
            end else if (do_wr) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit_in ? RESP_OKAY : RESP_SLVERR;
        end else if (axil_req_in.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_hit_in ? {24'h00_0000, rd_data_in} : 32'h0;
            rresp_q  <= rd_hit_in ? RESP_OKAY : RESP_SLVERR;
        end else if (axil_req_in.rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// ===== hdl/opd_product_term.sv
// One product term: AND of every enabled condition source
`timescale 1ns/1ns
module opd_product_term #(
    parameter int N = 26
) (
    input  wire logic [N-1:0] enable_in,
    input  wire logic [N-1:0] source_ok_in,
    output logic              term_out
);
    logic [N-1:0] pass;

    // A cleared enable makes its source count as true
    for (genvar i = 0; i < N; i++) begin : g_src
        assign pass[i] = source_ok_in[i] || !enable_in[i];
    end

    assign term_out = &pass;

endmodule

// ===== hdl/opd_top.sv
// Dependency logic for the third programmable output, both product terms
//
// Contract
// - Deassert output when either product is one
// - Zero enable bit excludes its source
// - 19h bits 0-3 select detector primary
// - 19h bits 4-5: detectors five, six
// - 19h bits 6-7 select both watchdogs
// - 1Ah bits 0-5 select detector secondary
// - General inputs at 1Ah[7:6], 1Bh[1:0]
// - 1Bh bits 2-3: outputs one, two
// - 1Bh bits 4-7: four further outputs
// - 1Ch bit 1: eighth output
// - 40h bit 2: assert while manual reset low
// - First product uses 16h-18h, 1Ch bit 0
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
module opd_top #(
    parameter int NUM_DETECTORS = 6,
    parameter int NUM_OUTPUTS   = 8
) (
    input  wire logic                   clk_in,
    input  wire logic                   arst_n_in,
    input  wire opd_pkg::opd_axil_req_t axil_req_in,
    output opd_pkg::opd_axil_rsp_t      axil_rsp_out,
    input  wire logic [5:0]             primary_ok_in,
    input  wire logic [5:0]             secondary_ok_in,
    input  wire logic [1:0]             watchdog_ok_in,
    input  wire logic [3:0]             general_logic_input_in,
    input  wire logic [6:0]             peer_output_idle_in,
    input  wire logic                   manual_reset_n_in,
    output logic                        output_three_assert_out,
    output logic                        product_one_out,
    output logic                        product_two_out
);
    import opd_pkg::*;

    if (NUM_DETECTORS != 4 && NUM_DETECTORS != 6) begin : g_bad_det
        $error("NUM_DETECTORS must be 4 or 6");
    end
    if (NUM_OUTPUTS != 5 && NUM_OUTPUTS != 8) begin : g_bad_out
        $error("NUM_OUTPUTS must be 5 or 8");
    end

    // Sources absent on the narrow variants never take part
    localparam logic [SRC_W-1:0] EN_MASK =
        ~((NUM_DETECTORS == 6 ? '0 : DET56_BITS) |
          (NUM_OUTPUTS == 8 ? '0 : OUT_WIDE_BITS));

    logic [7:0]       cfg_q [CFG_SLOTS];
    logic             wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0]       wr_data;
    logic             wr_hit;
    logic [2:0]       wr_slot;
    logic [IDX_W-1:0] rd_idx;
    logic             rd_hit;
    logic [7:0]       rd_data;
    logic [SRC_W-1:0] raw_src;
    logic [SRC_W-1:0] sync1_q;
    logic [SRC_W-1:0] src_ok_q;
    logic [SRC_W-1:0] en_one;
    logic [SRC_W-1:0] en_two;
    logic             prod_one;
    logic             prod_two;
    logic             assert_q;
    logic             prod_one_q;
    logic             prod_two_q;

    opd_axil_slave u_bus (
        .clk_in       (clk_in),
        .arst_n_in    (arst_n_in),
        .axil_req_in  (axil_req_in),
        .axil_rsp_out (axil_rsp_out),
        .wr_en_out    (wr_en),
        .wr_idx_out   (wr_idx),
        .wr_data_out  (wr_data),
        .wr_hit_in    (wr_hit),
        .rd_idx_out   (rd_idx),
        .rd_hit_in    (rd_hit),
        .rd_data_in   (rd_data)
    );

    // Maps a register index onto its storage slot
    function automatic logic [3:0] slot_of(input logic [IDX_W-1:0] idx);
        logic [3:0] s;
        s = 4'hf;
        unique case (idx)
            IDX_P1_PRIMARY:   s = 4'h0;
            IDX_P1_SECONDARY: s = 4'h1;
            IDX_P1_PEERS:     s = 4'h2;
            IDX_P2_PRIMARY:   s = 4'h3;
            IDX_P2_SECONDARY: s = 4'h4;
            IDX_P2_PEERS:     s = 4'h5;
            IDX_EIGHTH:       s = 4'h6;
            IDX_MANUAL:       s = 4'h7;
            default:          s = 4'hf;
        endcase
        return s;
    endfunction

    logic [3:0] wr_slot_full;
    logic [3:0] rd_slot_full;

    assign wr_slot_full = slot_of(wr_idx);
    assign rd_slot_full = slot_of(rd_idx);
    assign wr_slot      = wr_slot_full[2:0];
    assign wr_hit       = !wr_slot_full[3];
    assign rd_hit       = !rd_slot_full[3] || (rd_idx == IDX_STATUS);

    // Status word shows the registered terms and the output
    always_comb begin
        if (rd_idx == IDX_STATUS) begin
            rd_data = {5'h00, assert_q, prod_two_q, prod_one_q};
        end else if (!rd_slot_full[3]) begin
            rd_data = cfg_q[rd_slot_full[2:0]];
        end else begin
            rd_data = 8'h00;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < CFG_SLOTS; i++) begin
                cfg_q[i] <= CFG_RESET;
            end
        end else if (wr_en) begin
            cfg_q[wr_slot] <= wr_data;
        end
    end

    // Every condition source comes from outside this clock
    assign raw_src = {manual_reset_n_in,
                      peer_output_idle_in,
                      general_logic_input_in,
                      secondary_ok_in,
                      watchdog_ok_in,
                      primary_ok_in};

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_q  <= '1;
            src_ok_q <= '1;
        end else begin
            sync1_q  <= raw_src;
            src_ok_q <= sync1_q;
        end
    end

    // Enable vectors follow the source layout; the manual
    // reset select is shared by both terms
    logic [7:0] p1_prim;
    logic [7:0] p1_sec;
    logic [7:0] p1_peer;
    logic [7:0] p2_prim;
    logic [7:0] p2_sec;
    logic [7:0] p2_peer;
    logic [7:0] eighth;
    logic [7:0] manual;

    assign p1_prim = cfg_q[0];
    assign p1_sec  = cfg_q[1];
    assign p1_peer = cfg_q[2];
    assign p2_prim = cfg_q[3];
    assign p2_sec  = cfg_q[4];
    assign p2_peer = cfg_q[5];
    assign eighth  = cfg_q[6];
    assign manual  = cfg_q[7];

    assign en_one = EN_MASK & {manual[MANUAL_SEL_BIT],
                               eighth[EIGHTH_P1_BIT],
                               p1_peer, p1_sec, p1_prim};
    // Narrow variants drop the absent sources
    assign en_two = EN_MASK & {manual[MANUAL_SEL_BIT],
                               eighth[EIGHTH_P2_BIT],
                               p2_peer, p2_sec, p2_prim};

    opd_product_term #(.N(SRC_W)) u_term_one (
        .enable_in    (en_one),
        .source_ok_in (src_ok_q),
        .term_out     (prod_one)
    );

    opd_product_term #(.N(SRC_W)) u_term_two (
        .enable_in    (en_two),
        .source_ok_in (src_ok_q),
        .term_out     (prod_two)
    );

    // Output asserted in reset, otherwise only in the cycle after both terms are zero
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            assert_q   <= 1'b1;
            prod_one_q <= 1'b0;
            prod_two_q <= 1'b0;
        end else begin
            assert_q   <= !(prod_one || prod_two);
            prod_one_q <= prod_one;
            prod_two_q <= prod_two;
        end
    end

    assign output_three_assert_out = assert_q;
    assign product_one_out         = prod_one_q;
    assign product_two_out         = prod_two_q;

    // Checks

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic wide_det;
    logic wide_out;
    assign wide_det = (NUM_DETECTORS == 6);
    assign wide_out = (NUM_OUTPUTS == 8);

    a_deassert_on_term: assert property (
        (prod_one || prod_two) |=> !output_three_assert_out
    ) else $error("output stayed asserted with a true term");

    a_assert_both_zero: assert property (
        (!prod_one && !prod_two) |=>
            output_three_assert_out && !product_one_out
            && !product_two_out
    ) else $error("output not asserted with both terms zero");

    a_zero_enable_free: assert property (
        (en_two == '0) |-> prod_two
    ) else $error("second term false with no source enabled");

    a_primary_fault: assert property (
        (p2_prim[0] && !src_ok_q[SRC_PRIM]) |=> !product_two_out
    ) else $error("primary fault on detector one ignored");

    a_narrow_det_mask: assert property (
        !wide_det |-> (en_two[SRC_PRIM+5:SRC_PRIM+4] == 2'b00)
            && (en_two[SRC_SEC+5:SRC_SEC+4] == 2'b00)
    ) else $error("absent detector enabled on narrow variant");

    a_watchdog_fault: assert property (
        (p2_prim[7] && !src_ok_q[SRC_WDOG+1]) |-> !prod_two
    ) else $error("second watchdog fault ignored");

    a_secondary_fault: assert property (
        (p2_sec[2] && !src_ok_q[SRC_SEC+2]) |-> !prod_two
    ) else $error("secondary fault on detector three ignored");

    a_gpi_fault: assert property (
        (p2_peer[1] && !src_ok_q[SRC_GPI_HI+1]) |-> !prod_two
    ) else $error("fourth general input ignored");

    a_narrow_out_mask: assert property (
        !wide_out |-> (en_two[SRC_PEER12+1:SRC_PEER12] == 2'b00)
            && !en_two[SRC_EIGHTH]
    ) else $error("absent output enabled on narrow variant");

    a_peer_fault: assert property (
        (p2_peer[7] && !src_ok_q[SRC_PEERHI+3]) |-> !prod_two
    ) else $error("peer output dependency ignored");

    a_eighth_fault: assert property (
        (wide_out && eighth[EIGHTH_P2_BIT]
            && !src_ok_q[SRC_EIGHTH]) |-> !prod_two
    ) else $error("eighth output dependency ignored");

    sequence s_manual_low;
        (manual[MANUAL_SEL_BIT] && !manual_reset_n_in) [*4];
    endsequence

    a_manual_reset: assert property (
        s_manual_low |-> output_three_assert_out
    ) else $error("manual reset low did not assert output");

    a_first_term: assert property (
        (p1_prim[6] && !src_ok_q[SRC_WDOG]) |=> !product_one_out
    ) else $error("first term ignored first watchdog");

    a_all_good_true: assert property (
        (src_ok_q == '1) |-> prod_one && prod_two
    ) else $error("term false with every source good");

    // Each enabled source in fault must pull its own term low,
    // whatever its place in the vector
    for (genvar i = 0; i < SRC_W; i++) begin : g_src_chk
        a_src_fault_one: assert property (
            @(posedge clk_in) disable iff (!arst_n_in)
            (en_one[i] && !src_ok_q[i]) |-> !prod_one
        ) else $error("first term true with an enabled fault");

        a_src_fault_two: assert property (
            @(posedge clk_in) disable iff (!arst_n_in)
            (en_two[i] && !src_ok_q[i]) |-> !prod_two
        ) else $error("second term true with an enabled fault");
    end

    // A term is true as soon as no enabled source is in fault
    a_term_two_true: assert property (
        ((en_two & ~src_ok_q) == '0) |-> prod_two
    ) else $error("second term false with enabled sources good");

    a_term_one_true: assert property (
        ((en_one & ~src_ok_q) == '0) |-> prod_one
    ) else $error("first term false with enabled sources good");

    // The shared select drives both terms at once
    a_manual_both: assert property (
        (manual[MANUAL_SEL_BIT] && !src_ok_q[SRC_MANUAL])
            |-> !prod_one && !prod_two
    ) else $error("manual reset select missed a term");

    a_narrow_first_det: assert property (
        !wide_det |-> (en_one[SRC_PRIM+5:SRC_PRIM+4] == 2'b00)
            && (en_one[SRC_SEC+5:SRC_SEC+4] == 2'b00)
    ) else $error("absent detector enabled in first term");

    a_narrow_first_out: assert property (
        !wide_out |-> (en_one[SRC_PEER12+1:SRC_PEER12] == 2'b00)
            && !en_one[SRC_EIGHTH]
    ) else $error("absent output enabled in first term");

    // Bus writes land in the addressed slot only
    a_cfg_write_lands: assert property (
        wr_en |=> cfg_q[$past(wr_slot)] == $past(wr_data)
    ) else $error("register write did not land");

    a_unmapped_write: assert property (
        !wr_hit |-> !wr_en
    ) else $error("write enabled for an unmapped index");

endmodule

// ===== verification/opd_partner.sv
// Partner model: supply and reset sources feeding the output dependency block
`timescale 1ns/1ns
module opd_partner (
    input  wire logic        clk_in,
    input  wire logic [25:0] src_ok_in,
    output logic [5:0]       primary_ok_out,
    output logic [5:0]       secondary_ok_out,
    output logic [1:0]       watchdog_ok_out,
    output logic [3:0]       general_logic_input_out,
    output logic [6:0]       peer_output_idle_out,
    output logic             manual_reset_n_out
);
    // Every source reports 1 for its non-fault state
    always_ff @(posedge clk_in) begin
        primary_ok_out          <= src_ok_in[5:0];
        watchdog_ok_out         <= src_ok_in[7:6];
        secondary_ok_out        <= src_ok_in[13:8];
        general_logic_input_out <= src_ok_in[17:14];
        peer_output_idle_out    <= src_ok_in[24:18];
        manual_reset_n_out      <= src_ok_in[25];
    end
endmodule

// ===== verification/tb_top.sv
// Testbench for the output dependency block
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import opd_pkg::*;
    logic           clk_in;
    logic           arst_n_in;
    opd_axil_req_t  req;
    opd_axil_rsp_t  rsp;
    logic [25:0]    ok;
    logic [5:0]     prim;
    logic [5:0]     sec;
    logic [1:0]     wdog;
    logic [3:0]     gpi;
    logic [6:0]     peer;
    logic           mr_n;
    logic           out3;
    logic           p1;
    logic           p2;
    int             n_mismatch;
    int             n_checks;
    logic [11:0]    regs [8] = '{12'h058, 12'h05c, 12'h060, 12'h064,
                                 12'h068, 12'h06c, 12'h070, 12'h100};

    opd_partner partner (.clk_in(clk_in), .src_ok_in(ok),
        .primary_ok_out(prim), .secondary_ok_out(sec),
        .watchdog_ok_out(wdog), .general_logic_input_out(gpi),
        .peer_output_idle_out(peer), .manual_reset_n_out(mr_n));

    opd_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .axil_req_in(req), .axil_rsp_out(rsp), .primary_ok_in(prim),
        .secondary_ok_in(sec), .watchdog_ok_in(wdog),
        .general_logic_input_in(gpi), .peer_output_idle_in(peer),
        .manual_reset_n_in(mr_n), .output_three_assert_out(out3),
        .product_one_out(p1), .product_two_out(p2));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic conclude;
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic axw(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= s;
        req.bready  <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid && n < 50);
        r = rsp.bresp;
        req.bready <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            conclude();
        end
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_in);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid && n < 50);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // Let the partner, the synchronisers and the output register settle
    task automatic expect_state(input logic e1, input logic e2);
        logic [31:0] d;
        logic [1:0]  r;
        repeat (8) @(posedge clk_in);
        `CHK(p1, e1);
        `CHK(p2, e2);
        `CHK(out3, !(e1 | e2));
        axr(12'h140, d, r);
        `CHK(d, {29'h0, !(e1 | e2), e2, e1});
    endtask

    function automatic logic [11:0] sa(int i);
        if (i < 24) return 12'h064 + 12'(4 * (i / 8));
        else if (i == 24) return 12'h070;
        else return 12'h100;
    endfunction

    function automatic int sb(int i);
        if (i < 24) return i % 8;
        else if (i == 24) return EIGHTH_P2_BIT;
        else return MANUAL_SEL_BIT;
    endfunction

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          b;
        arst_n_in = 1'b0;
        req = '0;
        ok = '1;
        n_mismatch = 0;
        n_checks = 0;
        repeat (16) @(posedge clk_in);
        `CHK(out3, 1'b1);
        arst_n_in <= 1'b1;
        expect_state(1'b1, 1'b1);
        foreach (regs[k]) begin
            axr(regs[k], d, r);
            `CHK({r, d}, {RESP_OKAY, 32'h0});
        end
        // Unmapped places answer with an error and hold nothing
        axw(12'h204, 32'h0000_00ff, 4'h1, r);
        `CHK(r, RESP_SLVERR);
        axr(12'h204, d, r);
        `CHK({r, d}, {RESP_SLVERR, 32'h0});
        axw(12'h064, 32'hffff_ff01, 4'h0, r);
        `CHK(r, RESP_OKAY);
        axr(12'h064, d, r);
        `CHK(d, 32'h0);
        axw(12'h064, 32'hffff_ffa5, 4'h1, r);
        axr(12'h064, d, r);
        `CHK(d, 32'ha5);
        axw(12'h064, 32'h0, 4'h1, r);
        // Walk every source of the second term with the first held false
        for (int i = 0; i < 26; i++) begin
            b = (i == 6) ? 7 : 6;
            axw(12'h058, 32'(1 << b), 4'h1, r);
            ok <= ~(26'h1 << b);
            axw(sa(i), 32'(1 << sb(i)), 4'h1, r);
            axr(sa(i), d, r);
            `CHK(d, 32'(1 << sb(i)));
            expect_state(1'b0, 1'b1);
            ok <= ~((26'h1 << b) | (26'h1 << i));
            expect_state(1'b0, 1'b0);
            axw(sa(i), 32'h0, 4'h1, r);
            expect_state(1'b0, 1'b1);
            ok <= ~(26'h1 << b);
        end
        // The first term alone releases the output
        axw(12'h064, 32'h01, 4'h1, r);
        ok <= ~26'h41;
        expect_state(1'b0, 1'b0);
        axw(12'h058, 32'h0, 4'h1, r);
        expect_state(1'b1, 1'b0);
        axw(12'h058, 32'h01, 4'h1, r);
        expect_state(1'b0, 1'b0);
        ok <= '1;
        expect_state(1'b1, 1'b1);
        // Mid-run reset asserts the output and clears the bytes
        axw(12'h064, 32'h01, 4'h1, r);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        `CHK(out3, 1'b1);
        arst_n_in <= 1'b1;
        axr(12'h064, d, r);
        `CHK({r, d}, {RESP_OKAY, 32'h0});
        expect_state(1'b1, 1'b1);
        conclude();
    end
endmodule
